//--- hw/pmc_regs.vh
// Register map, field positions and timing counts of the panel meter
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PMC_CTRL_OFF      8'h00
`define PMC_RESULT_OFF    8'h04
`define PMC_ISTAT_OFF     8'h08
`define PMC_IMASK_OFF     8'h0C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PMC_CTRL_TRIG_BIT  0
`define PMC_CTRL_BLANK_BIT 1
`define PMC_CTRL_RST       1'h0
`define PMC_RES_KILO_BIT   12
`define PMC_RES_OVL_BIT    13
`define PMC_RES_POS_BIT    14
`define PMC_RES_BUSY_BIT   15
`define PMC_IRQ_DONE_BIT   0
`define PMC_IRQ_OVL_BIT    1
`define PMC_IRQ_DROP_BIT   2
`define PMC_IRQ_W          3
`define PMC_IRQ_RST        3'h0
`define PMC_CNT_RST        13'h0000
`define PMC_FULL_COUNT     13'h1999
`define PMC_OVR_COUNT      1000
`define PMC_OVL_COUNT      2000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMC_CLK_HZ        40000000
`define PMC_CONV_MAX_MS   10
`define PMC_CONV_MAX_CYC  (`PMC_CONV_MAX_MS * (`PMC_CLK_HZ / 1000))
`define PMC_ITRIG_RATE    6
`define PMC_ITRIG_CYC     (`PMC_CLK_HZ / `PMC_ITRIG_RATE)
`define PMC_ITRIG_W_US    100
`define PMC_ITRIG_W_CYC   (`PMC_ITRIG_W_US * (`PMC_CLK_HZ / 1000000))
`define PMC_TICK_CYC      100
`define PMC_UP_TICKS      1000

`endif

//--- hw/pmc_conversion_control.v
// Conversion sequencer, data outputs, display gating and APB registers
`timescale 1ns/10ps
`include "pmc_regs.vh"

module pmc_conversion_control #(
  parameter ITRIG_CYC    = `PMC_ITRIG_CYC,    // Internal trigger period
  parameter CONV_MAX_CYC = `PMC_CONV_MAX_CYC, // Conversion guard time
  parameter TICK_CYC     = `PMC_TICK_CYC,     // Converter clock period
  parameter UP_TICKS     = `PMC_UP_TICKS      // Integrate-up length
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Meter control inputs
  input  wire        ext_trig,
  input  wire        hold_n,
  input  wire        blank_n,
  // Analog front end
  input  wire        cmp_above,
  input  wire        in_neg,
  input  wire        line_pos,
  // Meter outputs
  output wire        int_trig_out,
  output wire        status,
  output wire [3:0]  bcd_units,
  output wire [3:0]  bcd_tens,
  output wire [3:0]  bcd_hund,
  output wire        overrange_n,
  output wire        overload_n,
  output wire        polarity,
  // Display drive
  output wire        disp_digits_on,
  output wire        disp_one_on,
  output wire        disp_sign_on,
  // Interrupt
  output wire        irq
);

  // --------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;  // Waiting for a trigger
  localparam [1:0] ST_UP   = 2'h1;  // Fixed integrate-up phase
  localparam [1:0] ST_DOWN = 2'h2;  // Ramp-down, counting
  localparam integer ITL  = ITRIG_CYC - 1;
  localparam integer CML  = CONV_MAX_CYC - 1;
  localparam integer TKL  = TICK_CYC - 1;
  localparam integer UPL  = UP_TICKS - 1;
  localparam integer ITW  = `PMC_ITRIG_W_CYC;
  localparam [22:0] ITRIG_LAST = ITL[22:0];
  localparam [22:0] ITRIG_W    = ITW[22:0];
  localparam [18:0] CONV_LAST  = CML[18:0];
  localparam [6:0]  TICK_LAST  = TKL[6:0];
  localparam [9:0]  UP_LAST    = UPL[9:0];

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [1:0]  state_reg;     // Sequencer state
  reg         busy_reg;      // Status line
  reg  [12:0] cnt_reg;       // Kilo bit plus three BCD digits
  reg         ovr_n_reg;     // Overrange, active low
  reg         ovl_n_reg;     // Overload, active low
  reg         pos_reg;       // Latched polarity
  reg  [6:0]  tick_reg;      // Converter clock divider
  reg  [9:0]  up_reg;        // Integrate-up tick count
  reg  [18:0] guard_reg;     // Conversion time guard
  reg  [22:0] itrig_reg;     // Internal trigger timer
  reg         itrig_o_reg;   // Internal trigger output
  reg         trig_d_reg;    // Trigger input, last cycle
  reg         dig_on_reg;    // Data digits lit
  reg         one_on_reg;    // Leading one lit
  reg         sign_on_reg;   // Minus sign lit
  reg         blank_reg;     // Software blank request
  reg         swtrig_reg;    // Software trigger pulse
  reg  [2:0]  istat_reg;     // Sticky event flags
  reg  [2:0]  imask_reg;     // Event enables
  reg         irq_reg;       // Interrupt output
  reg  [31:0] prdata_reg;    // Read data
  reg         pready_reg;    // Access completion
  reg         pslverr_reg;   // Unmapped address answer

  // --------------------------------------------------------------------
  // Combinational terms
  // --------------------------------------------------------------------
  wire        tick;          // One converter clock period
  wire        trig_rise;     // Start request from pin or software
  wire        start;         // Accepted start
  wire        drop;          // Start request that was ignored
  wire        finish;        // Conversion ends this cycle
  wire        ovl_hit;       // Count would pass full scale on this tick
  wire        acc;           // APB access phase, first cycle
  wire        wr;            // Write strobe
  wire        mapped;        // Address hits a register
  wire [12:0] cnt_inc;       // Count plus one, BCD
  wire [2:0]  ev;            // Events raised this cycle
  wire [2:0]  clr;           // Flags cleared by software
  wire [2:0]  istat_next;    // Next value of the flags
  wire        disp_en;       // Display may be lit

  // BCD increment across three digits and the kilo bit
  function [12:0] bcd_inc;
    input [12:0] v;
    reg   [12:0] r;
    reg          c;
    integer      i;
    begin
      r = v;
      c = 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        if (c && r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else if (c) begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
      r[12] = r[12] | c;
      bcd_inc = r;
    end
  endfunction

  assign cnt_inc = bcd_inc(cnt_reg);
  assign tick    = (tick_reg == TICK_LAST);

  // Rising edge only, so any width up to the limit starts one conversion
  assign trig_rise = (ext_trig & ~trig_d_reg) | swtrig_reg;
  // Hold low or a running conversion swallows the request
  assign start = trig_rise & hold_n & (state_reg == ST_IDLE);
  assign drop  = trig_rise & ~start;

  // Full scale is 1999; the next count would be 2000
  assign ovl_hit = (state_reg == ST_DOWN) & tick & cmp_above &
                   (cnt_reg == `PMC_FULL_COUNT);
  // Guard forces an end so the cycle never runs past its window
  assign finish = ((state_reg == ST_DOWN) & tick &
                   (~cmp_above | ovl_hit)) |
                  ((state_reg != ST_IDLE) & (guard_reg == CONV_LAST));

  // --------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------
  // Dual slope: fixed integrate-up, then count until the comparator
  // drops. Tick and up counts keep the worst case at 7.5 ms.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      busy_reg  <= 1'b0;
      tick_reg  <= 7'h00;
      up_reg    <= 10'h000;
      guard_reg <= 19'h00000;
    end else begin
      // Divider always runs; restarted on each start
      tick_reg  <= (start || tick) ? 7'h00 : tick_reg + 7'h01;
      // Guard counts only while converting
      guard_reg <= (state_reg == ST_IDLE) ? 19'h00000 :
                   guard_reg + 19'h00001;
      case (state_reg)
        ST_IDLE: begin
          up_reg <= 10'h000;
          if (start) begin
            state_reg <= ST_UP;
            busy_reg  <= 1'b1;
          end
        end
        ST_UP: begin
          if (finish) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
          end else if (tick) begin
            up_reg <= up_reg + 10'h001;
            if (up_reg == UP_LAST) begin
              state_reg <= ST_DOWN;
            end
          end
        end
        ST_DOWN: begin
          // Status falls only once every output is settled
          if (finish) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Counters, range flags and polarity
  // --------------------------------------------------------------------
  // Outputs are the live counters, so data is valid only with status low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= `PMC_CNT_RST;
      ovr_n_reg <= 1'b1;
      ovl_n_reg <= 1'b1;
      pos_reg   <= 1'b1;
    end else begin
      if (start) begin
        cnt_reg   <= `PMC_CNT_RST;
        ovr_n_reg <= 1'b1;
        ovl_n_reg <= 1'b1;
      end else if (ovl_hit || (finish && state_reg == ST_UP)) begin
        ovl_n_reg <= 1'b0;
        ovr_n_reg <= 1'b0;
      end else if (state_reg == ST_DOWN && tick && cmp_above &&
                   !finish) begin
        cnt_reg   <= cnt_inc;
        // Kilo bit set means 1000 counts or more
        ovr_n_reg <= ~cnt_inc[`PMC_RES_KILO_BIT];
      end
      // Sign caught at the end of integrate-up and held to the next
      if (state_reg == ST_UP && tick && up_reg == UP_LAST) begin
        pos_reg <= ~in_neg;
      end
    end
  end

  // --------------------------------------------------------------------
  // Internal trigger generator
  // --------------------------------------------------------------------
  // Free-running; loops back to the trigger input for 6 per second.
  // Pulse width sits well inside the allowed trigger width.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      itrig_reg   <= 23'h000000;
      itrig_o_reg <= 1'b0;
      trig_d_reg  <= 1'b0;
    end else begin
      itrig_reg   <= (itrig_reg == ITRIG_LAST) ? 23'h000000 :
                     itrig_reg + 23'h000001;
      itrig_o_reg <= (itrig_reg < ITRIG_W);
      trig_d_reg  <= ext_trig;
    end
  end

  // --------------------------------------------------------------------
  // Display gating
  // --------------------------------------------------------------------
  // Shown in the positive line half, dark while converting. Blank only
  // gates the lamps, so the data path never sees it.
  assign disp_en = line_pos & blank_n & ~blank_reg & ~busy_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_on_reg  <= 1'b0;
      one_on_reg  <= 1'b0;
      sign_on_reg <= 1'b0;
    end else begin
      // Overload: data digits dark, leading one lit, sign kept
      dig_on_reg  <= disp_en & ovl_n_reg;
      one_on_reg  <= disp_en & (cnt_reg[`PMC_RES_KILO_BIT] |
                     ~ovl_n_reg);
      sign_on_reg <= disp_en & ~pos_reg;
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // One wait state: work done in the first access cycle, pready next
  assign acc    = psel & penable & ~pready_reg;
  assign wr     = acc & pwrite;
  assign mapped = (paddr == `PMC_CTRL_OFF) | (paddr == `PMC_RESULT_OFF) |
                  (paddr == `PMC_ISTAT_OFF) | (paddr == `PMC_IMASK_OFF);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
      blank_reg   <= `PMC_CTRL_RST;
      swtrig_reg  <= 1'b0;
      imask_reg   <= `PMC_IRQ_RST;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~mapped;
      // Software trigger is a one-cycle pulse
      swtrig_reg  <= wr & (paddr == `PMC_CTRL_OFF) &
                     pwdata[`PMC_CTRL_TRIG_BIT];
      if (wr && paddr == `PMC_CTRL_OFF) begin
        blank_reg <= pwdata[`PMC_CTRL_BLANK_BIT];
      end
      if (wr && paddr == `PMC_IMASK_OFF) begin
        imask_reg <= pwdata[2:0];
      end
      // Read data is registered; zero for writes and holes
      prdata_reg <= 32'h00000000;
      if (acc && !pwrite) begin
        case (paddr)
          `PMC_CTRL_OFF:   prdata_reg <= {30'h0, blank_reg, 1'b0};
          `PMC_RESULT_OFF: prdata_reg <= {16'h0, busy_reg, pos_reg,
                                          ~ovl_n_reg, cnt_reg};
          `PMC_ISTAT_OFF:  prdata_reg <= {29'h0, istat_reg};
          `PMC_IMASK_OFF:  prdata_reg <= {29'h0, imask_reg};
          default:         prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt flags
  // --------------------------------------------------------------------
  // Write one to clear; a new event in the same cycle wins
  assign ev = {drop, ovl_hit, finish};  // Dropped, overload, done
  assign clr = (wr && paddr == `PMC_ISTAT_OFF) ? pwdata[2:0] : 3'h0;
  assign istat_next = (istat_reg & ~clr) | ev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= `PMC_IRQ_RST;
      irq_reg   <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      irq_reg   <= |(istat_next & imask_reg);
    end
  end

  // --------------------------------------------------------------------
  // Output drive
  // --------------------------------------------------------------------
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign int_trig_out   = itrig_o_reg;
  assign status         = busy_reg;
  assign bcd_units      = cnt_reg[3:0];
  assign bcd_tens       = cnt_reg[7:4];
  assign bcd_hund       = cnt_reg[11:8];
  assign overrange_n    = ovr_n_reg;
  assign overload_n     = ovl_n_reg;
  assign polarity       = pos_reg;
  assign disp_digits_on = dig_on_reg;
  assign disp_one_on    = one_on_reg;
  assign disp_sign_on   = sign_on_reg;
  assign irq            = irq_reg;

endmodule

//--- sim/pmc_checker.sv
// Port-level property checker for the panel meter control
`timescale 1ns/10ps
module pmc_checker (
  // Clock and reset
  input wire       pclk,
  input wire       presetn,
  // Meter controls
  input wire       ext_trig,
  input wire       hold_n,
  input wire       blank_n,
  // Meter outputs
  input wire       status,
  input wire [3:0] bcd_units,
  input wire [3:0] bcd_tens,
  input wire [3:0] bcd_hund,
  input wire       overrange_n,
  input wire       overload_n,
  input wire       polarity,
  input wire       disp_digits_on,
  input wire       disp_one_on,
  input wire       disp_sign_on
);
  // --------------------------------------------------------------
  // Common clocking, reset masks every check
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  trig_start_a: assert property (
    $rose(ext_trig) && hold_n && !status |=> status)
    else $error("trigger edge did not start a conversion");
  hold_block_a: assert property (
    !hold_n && !status |=> !status)
    else $error("conversion started while held");
  busy_ignore_a: assert property (
    status && $rose(ext_trig) |=>
      {!overrange_n, bcd_hund, bcd_tens, bcd_units} >=
      $past({!overrange_n, bcd_hund, bcd_tens, bcd_units}))
    else $error("retrigger disturbed a conversion");
  ovl_ovr_a: assert property (
    !overload_n |-> !overrange_n)
    else $error("overload without overrange");
  ovl_dark_a: assert property (
    !overload_n |=> !disp_digits_on)
    else $error("digits lit on overload");
  blank_dark_a: assert property (
    !blank_n |=> !disp_digits_on && !disp_one_on && !disp_sign_on)
    else $error("display lit while blanked");
  pol_hold_a: assert property (
    !status |=> $stable(polarity))
    else $error("sign moved while idle");
  bcd_hold_a: assert property (
    !status ##1 !status |-> $stable({bcd_hund, bcd_tens, bcd_units}))
    else $error("digits moved while idle");
endmodule

bind pmc_conversion_control pmc_checker pmc_checker_i (
  .pclk(pclk), .presetn(presetn), .ext_trig(ext_trig),
  .hold_n(hold_n), .blank_n(blank_n), .status(status),
  .bcd_units(bcd_units), .bcd_tens(bcd_tens), .bcd_hund(bcd_hund),
  .overrange_n(overrange_n), .overload_n(overload_n),
  .polarity(polarity), .disp_digits_on(disp_digits_on),
  .disp_one_on(disp_one_on), .disp_sign_on(disp_sign_on));

//--- sim/pmc_front_model.sv
// Front end model: comparator, input sign and ac line phase
`timescale 1ns/10ps
`include "pmc_regs.vh"
module pmc_front_model #(
  parameter LINE_HALF = 500,            // Half line period, shortened
  parameter TICK      = `PMC_TICK_CYC,  // Converter clock period
  parameter UPT       = `PMC_UP_TICKS   // Integrate-up length in ticks
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Conversion state and wanted reading
  input  wire        status,
  input  wire [12:0] target,
  input  wire        neg,
  // Front end levels
  output reg         cmp_above,
  output wire        in_neg,
  output reg         line_pos
);
  localparam UP = UPT * TICK;  // Integrate-up span
  reg [19:0] t;   // Cycles since conversion start
  reg [9:0]  lc;  // Line phase counter
  assign in_neg = neg;  // Sign held over the whole conversion
  // --------------------------------------------------------------
  // Comparator: edge placed mid-tick so alignment keeps the count
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t <= 20'h00000;
      cmp_above <= 1'b0;
    end else begin
      t <= status ? t + 20'h00001 : 20'h00000;
      cmp_above <= status && (t < UP + target * TICK + TICK / 2);
    end
  end
  // Line phase: display only in the positive half
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc <= 10'h000;
      line_pos <= 1'b0;
    end else if (lc == LINE_HALF - 1) begin
      lc <= 10'h000;
      line_pos <= ~line_pos;
    end else
      lc <= lc + 10'h001;
  end
endmodule

//--- sim/tb_pmc_conversion_control.sv
// Self-checking bench for the panel meter conversion control
`timescale 1ns/10ps
`include "pmc_regs.vh"
module tb_pmc_conversion_control;
  localparam ITRIG = 6000;  // Shortened internal trigger period
  localparam TICK  = 10;    // Shortened converter clock period
  localparam UPT   = 20;    // Shortened integrate-up length
  // Clock, reset and APB
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr;
  // Meter side
  reg         trig_drv, loop_on, hold_n, blank_n, neg;
  reg  [12:0] target;
  wire        ext_trig, cmp_above, in_neg, line_pos, int_trig_out;
  wire        status, overrange_n, overload_n, polarity, irq;
  wire [3:0]  bcd_units, bcd_tens, bcd_hund;
  wire        disp_digits_on, disp_one_on, disp_sign_on;
  // Bookkeeping
  integer     err_count, n_checks, seed, n;
  reg  [31:0] rd;
  reg  [11:0] t1, t2;
  // Internal trigger looped back on request
  assign ext_trig = loop_on ? int_trig_out : trig_drv;

  pmc_conversion_control #(.ITRIG_CYC(ITRIG), .CONV_MAX_CYC(25000),
    .TICK_CYC(TICK), .UP_TICKS(UPT))
    pmc_conversion_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trig(ext_trig),
    .hold_n(hold_n), .blank_n(blank_n), .cmp_above(cmp_above),
    .in_neg(in_neg), .line_pos(line_pos), .int_trig_out(int_trig_out),
    .status(status), .bcd_units(bcd_units), .bcd_tens(bcd_tens),
    .bcd_hund(bcd_hund), .overrange_n(overrange_n),
    .overload_n(overload_n), .polarity(polarity),
    .disp_digits_on(disp_digits_on), .disp_one_on(disp_one_on),
    .disp_sign_on(disp_sign_on), .irq(irq));
  pmc_front_model #(.TICK(TICK), .UPT(UPT)) pmc_front_model_i (
    .pclk(pclk), .presetn(presetn), .status(status), .target(target),
    .neg(neg), .cmp_above(cmp_above), .in_neg(in_neg),
    .line_pos(line_pos));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function [11:0] bcd(input [11:0] v);
    bcd = ((v / 100) << 8) | (((v / 10) % 10) << 4) | (v % 10);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("Error %0t: %0s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge pclk);
  endtask
  // One APB transfer; waits on pready, never a fixed count
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k = k + 1;
    end
    rd = pslverr ? 32'hEEEEEEEE : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k < 20, 1, "no pready");
    @(posedge pclk);
  endtask
  // Short positive pulse, far under the width ceiling
  task pulse;
    trig_drv <= 1'b1;
    cyc(3);
    trig_drv <= 1'b0;
    cyc(1);
  endtask
  task wait_st(input v, input integer lim);
    n = 0;
    while (status !== v && n < lim) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk(n < lim, 1, "status wait");
  endtask
  // Fresh positive line half, display settled
  task at_line;
    while (line_pos) @(posedge pclk);
    while (!line_pos) @(posedge pclk);
    cyc(3);
  endtask
  task convert(input [11:0] t, input ng);
    target <= {1'b0, t};
    neg <= ng;
    pulse;
    chk(status, 1, "start");
    cyc(UPT * TICK + 2 * TICK);
    pulse;
    chk(status, 1, "busy");
    wait_st(1'b0, 400000);
    chk({bcd_hund, bcd_tens, bcd_units}, bcd(t), "digits");
    chk(polarity, !ng, "sign");
    chk({overrange_n, overload_n}, 2'h3, "flags");
  endtask
  task results;
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog, main sequence
  // --------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #2000000;
    err_count = err_count + 1;
    results;
  end
  initial begin
    {psel, penable, pwrite, trig_drv, loop_on, neg} = 6'h00;
    {presetn, paddr, pwdata, target} = 54'h0;
    {hold_n, blank_n} = 2'h3;
    err_count = 0;
    n_checks = 0;
    seed = 32'hAE21;
    cyc(8);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({status, overrange_n, overload_n, polarity}, 4'h7, "reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'hEEEEEEEE, "unmapped");
    apb(1'b1, `PMC_IMASK_OFF, 32'h7);
    apb(1'b0, `PMC_IMASK_OFF, 32'h0);
    chk(rd, 32'h7, "mask");
    t1 = 20 + ($unsigned($random(seed)) % 60);
    t2 = 20 + ($unsigned($random(seed)) % 60);
    convert(t1, 1'b0);
    apb(1'b0, `PMC_ISTAT_OFF, 32'h0);
    chk(rd, 32'h5, "done and dropped");
    chk(irq, 1, "irq on");
    apb(1'b1, `PMC_ISTAT_OFF, 32'h7);
    cyc(2);
    chk(irq, 0, "irq clear");
    hold_n <= 1'b0;
    pulse;
    cyc(3);
    chk(status, 0, "held");
    chk({bcd_hund, bcd_tens, bcd_units}, bcd(t1), "kept");
    hold_n <= 1'b1;
    apb(1'b1, `PMC_IMASK_OFF, 32'h0);
    cyc(2);
    chk(irq, 0, "masked");
    apb(1'b1, `PMC_ISTAT_OFF, 32'h7);
    apb(1'b1, `PMC_IMASK_OFF, 32'h7);
    convert(t2, 1'b1);
    at_line;
    chk({disp_digits_on, disp_sign_on}, 2'h3, "lit");
    blank_n <= 1'b0;
    cyc(3);
    chk({disp_digits_on, disp_sign_on}, 2'h0, "dark");
    chk({bcd_hund, bcd_tens, bcd_units}, bcd(t2), "data");
    blank_n <= 1'b1;
    cyc(3);
    chk(disp_digits_on, 1, "unblank");
    while (int_trig_out) @(posedge pclk);
    while (!int_trig_out) @(posedge pclk);
    n = 0;
    while (int_trig_out) begin
      @(posedge pclk);
      n = n + 1;
    end
    while (!int_trig_out) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk(n, ITRIG, "trigger period");
    target <= 13'h07D0;  // Exactly the overload count
    neg <= 1'b0;
    while (int_trig_out) @(posedge pclk);
    loop_on <= 1'b1;
    wait_st(1'b1, 2 * ITRIG);
    loop_on <= 1'b0;
    wait_st(1'b0, 400000);
    chk({overrange_n, overload_n}, 2'h0, "overload");
    chk(polarity, 1, "sign valid");
    at_line;
    chk({disp_digits_on, disp_one_on}, 2'h1, "one only");
    results;
  end
endmodule
